// [hw/dpvc_top.v]
// Behaviour
// R1: record engine flags A bit6, B bit5
// R2: playback engine flags A bit2, B bit1
// R3: record counter restarts per frame unless bit4
// R4: playback counter restarts per frame unless bit0
// R5: bit7 powers left DAC, resets off
// R6: bit6 powers right DAC, resets off
// R7: left routing off/left/right/average
// R8: right routing off/right/left/average
// R9: step every sample or every two
// R10: code 10 unstepped; software avoids 11
// R11: bit3 mutes left, resets muted
// R12: bit2 mutes right, resets muted
// R13: coupling copies one gain to other
// R14: compression forces independent volumes
// R15: left gain signed half-dB code
// R16: software avoids reserved gain codes
// R17: software writes zero upper bits
// R18: right gain same code set
// R19: step 0.5 dB toward target
// R20: reset values, reads return writes
`timescale 1ns/1ps
`default_nettype none
`include "dpvc_regs.vh"
module dpvc_top #(
  parameter SW = 24
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // register port
  input wire regWr,
  input wire [6:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  // audio frame and sample timing
  input wire frameStart,
  input wire sampleTick,
  input wire rangeCompOn,
  // samples in
  input wire [SW-1:0] leftSample,
  input wire [SW-1:0] rightSample,
  // engine controls
  output reg recFlagA,
  output reg recFlagB,
  output reg recCntClear,
  output reg playFlagA,
  output reg playFlagB,
  output reg playCntClear,
  // dac controls
  output reg leftPowerUp,
  output reg rightPowerUp,
  output reg leftMute,
  output reg rightMute,
  output reg [SW-1:0] leftDacIn,
  output reg [SW-1:0] rightDacIn,
  output reg [7:0] leftGainOut,
  output reg [7:0] rightGainOut
);

  // ************************
  // register file
  // ************************
  reg [7:0] flags_reg;
  reg [7:0] setup_reg;
  reg [7:0] mute_reg;
  reg [7:0] lgain_reg;
  reg [7:0] rgain_reg;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= `DPVC_RST_FLAGS; // R20
      setup_reg <= `DPVC_RST_SETUP; // R5 R6
      mute_reg <= `DPVC_RST_MUTE; // R11 R12
      lgain_reg <= `DPVC_RST_GAIN;
      rgain_reg <= `DPVC_RST_GAIN;
    end else if (regWr) begin
      case (regAddr)
        `DPVC_OFS_FLAGS: flags_reg <= regWrData;
        `DPVC_OFS_SETUP: setup_reg <= regWrData;
        `DPVC_OFS_MUTE: mute_reg <= regWrData;
        `DPVC_OFS_LGAIN: lgain_reg <= regWrData; // R15
        `DPVC_OFS_RGAIN: rgain_reg <= regWrData; // R18
        default: flags_reg <= flags_reg;
      endcase
    end
  end

  // unmapped offsets read zero
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else begin
      case (regAddr)
        `DPVC_OFS_FLAGS: regRdData <= flags_reg; // R20
        `DPVC_OFS_SETUP: regRdData <= setup_reg;
        `DPVC_OFS_MUTE: regRdData <= mute_reg;
        `DPVC_OFS_LGAIN: regRdData <= lgain_reg;
        `DPVC_OFS_RGAIN: regRdData <= rgain_reg;
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // ************************
  // gain selection and stepping
  // ************************
  wire [1:0] coupling = mute_reg[1:0];
  wire [1:0] stepMode = setup_reg[1:0];
  reg [7:0] leftTarget;
  reg [7:0] rightTarget;
  reg halfTick_reg;
  wire stepEn;
  wire stepBypass;
  wire [7:0] lApplied;
  wire [7:0] rApplied;

  always @* begin
    leftTarget = lgain_reg;
    rightTarget = rgain_reg;
    // compression keeps volumes independent
    if (!rangeCompOn) begin // R14
      if (coupling == `DPVC_CPL_L_FROM_R) begin
        leftTarget = rgain_reg; // R13
      end else if (coupling == `DPVC_CPL_R_FROM_L) begin
        rightTarget = lgain_reg; // R13
      end
    end
  end

  // divide sample ticks by two for the slow step rate
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      halfTick_reg <= 1'b0;
    end else if (sampleTick) begin
      halfTick_reg <= ~halfTick_reg;
    end
  end

  // code 11 is reserved; it steps like 00 here
  assign stepEn = sampleTick && ((stepMode != `DPVC_STEP_TWO) || halfTick_reg); // R9
  assign stepBypass = (stepMode == `DPVC_STEP_OFF); // R10

  dpvc_gain_ramp uLeftRamp (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .stepEn(stepEn),
    .stepBypass(stepBypass),
    .targetGain(leftTarget),
    .gain_reg(lApplied)
  );

  dpvc_gain_ramp uRightRamp (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .stepEn(stepEn),
    .stepBypass(stepBypass),
    .targetGain(rightTarget),
    .gain_reg(rApplied)
  );

  // ************************
  // routing
  // ************************
  wire [SW:0] sampleSum = {leftSample[SW-1], leftSample} + {rightSample[SW-1], rightSample};
  wire [SW-1:0] sampleAvg = sampleSum[SW:1];
  reg [SW-1:0] leftSel;
  reg [SW-1:0] rightSel;

  always @* begin
    case (setup_reg[5:4])
      `DPVC_RT_SAME: leftSel = leftSample; // R7
      `DPVC_RT_CROSS: leftSel = rightSample;
      `DPVC_RT_AVG: leftSel = sampleAvg;
      default: leftSel = {SW{1'b0}};
    endcase
    case (setup_reg[3:2])
      `DPVC_RT_SAME: rightSel = rightSample; // R8
      `DPVC_RT_CROSS: rightSel = leftSample;
      `DPVC_RT_AVG: rightSel = sampleAvg;
      default: rightSel = {SW{1'b0}};
    endcase
  end

  // ************************
  // registered outputs
  // ************************
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      recFlagA <= 1'b0;
      recFlagB <= 1'b0;
      recCntClear <= 1'b0;
      playFlagA <= 1'b0;
      playFlagB <= 1'b0;
      playCntClear <= 1'b0;
      leftPowerUp <= 1'b0;
      rightPowerUp <= 1'b0;
      leftMute <= 1'b1;
      rightMute <= 1'b1;
      leftDacIn <= {SW{1'b0}};
      rightDacIn <= {SW{1'b0}};
      leftGainOut <= 8'h00;
      rightGainOut <= 8'h00;
    end else begin
      recFlagA <= flags_reg[`DPVC_BIT_REC_A]; // R1
      recFlagB <= flags_reg[`DPVC_BIT_REC_B]; // R1
      playFlagA <= flags_reg[`DPVC_BIT_PLAY_A]; // R2
      playFlagB <= flags_reg[`DPVC_BIT_PLAY_B]; // R2
      // one-cycle clear pulse at frame start
      recCntClear <= frameStart && !flags_reg[`DPVC_BIT_REC_RUN]; // R3
      playCntClear <= frameStart && !flags_reg[`DPVC_BIT_PLAY_RUN]; // R4
      leftPowerUp <= setup_reg[`DPVC_BIT_LPWR]; // R5
      rightPowerUp <= setup_reg[`DPVC_BIT_RPWR]; // R6
      leftMute <= mute_reg[`DPVC_BIT_LMUTE]; // R11
      rightMute <= mute_reg[`DPVC_BIT_RMUTE]; // R12
      leftDacIn <= leftSel;
      rightDacIn <= rightSel;
      leftGainOut <= lApplied;
      rightGainOut <= rApplied;
    end
  end

endmodule
`default_nettype wire

// [inc/dpvc_regs.vh]
`ifndef DPVC_REGS_VH
`define DPVC_REGS_VH

// register offsets (page 0)
`define DPVC_OFS_FLAGS 7'h3E
`define DPVC_OFS_SETUP 7'h3F
`define DPVC_OFS_MUTE 7'h40
`define DPVC_OFS_LGAIN 7'h41
`define DPVC_OFS_RGAIN 7'h42

// reset values
`define DPVC_RST_FLAGS 8'h00
`define DPVC_RST_SETUP 8'h14
`define DPVC_RST_MUTE 8'h0C
`define DPVC_RST_GAIN 8'h00

// field positions
`define DPVC_BIT_REC_A 6
`define DPVC_BIT_REC_B 5
`define DPVC_BIT_REC_RUN 4
`define DPVC_BIT_PLAY_A 2
`define DPVC_BIT_PLAY_B 1
`define DPVC_BIT_PLAY_RUN 0
`define DPVC_BIT_LPWR 7
`define DPVC_BIT_RPWR 6
`define DPVC_BIT_LMUTE 3
`define DPVC_BIT_RMUTE 2

// soft-step codes
`define DPVC_STEP_EVERY 2'h0
`define DPVC_STEP_TWO 2'h1
`define DPVC_STEP_OFF 2'h2

// coupling codes
`define DPVC_CPL_L_FROM_R 2'h1
`define DPVC_CPL_R_FROM_L 2'h2

// routing codes
`define DPVC_RT_OFF 2'h0
`define DPVC_RT_SAME 2'h1
`define DPVC_RT_CROSS 2'h2
`define DPVC_RT_AVG 2'h3

`endif

// [hw/dpvc_gain_ramp.v]
`timescale 1ns/1ps
`default_nettype none
// one channel of soft-stepped applied gain
module dpvc_gain_ramp (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // control
  input wire stepEn,
  input wire stepBypass,
  input wire [7:0] targetGain,
  // applied gain
  output reg [7:0] gain_reg
);

  reg [7:0] gain_next;

  always @* begin
    gain_next = gain_reg;
    if (stepBypass) begin
      gain_next = targetGain; // R10
    end else if (stepEn && gain_reg != targetGain) begin
      // signed compare; 0.5 dB per step toward target
      if ($signed(gain_reg) < $signed(targetGain)) begin
        gain_next = gain_reg + 8'h01; // R19
      end else begin
        gain_next = gain_reg - 8'h01; // R19
      end
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_reg <= 8'h00;
    end else begin
      gain_reg <= gain_next;
    end
  end

endmodule
`default_nettype wire

// [bench/dpvc_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// register to output checks
// ****
module dpvc_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic regWr,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  // engine and dac controls
  input wire logic frameStart,
  input wire logic recFlagA,
  input wire logic recFlagB,
  input wire logic recCntClear,
  input wire logic playFlagA,
  input wire logic playFlagB,
  input wire logic playCntClear,
  input wire logic leftPowerUp,
  input wire logic rightPowerUp,
  input wire logic leftMute,
  input wire logic rightMute
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // 7F marks no write two cycles back
  logic [6:0] a1, a2;
  logic [7:0] d1, d2;
  always_ff @(posedge sys_clk) begin
    a1 <= regWr ? regAddr : 7'h7F;
    a2 <= a1;
    d1 <= regWrData;
    d2 <= d1;
  end
  AST_FLAGS: assert property (a2 == 7'h3E |-> {recFlagA, recFlagB} == d2[6:5])
    else $error("record flags wrong");
  AST_PFLAGS: assert property (a2 == 7'h3E |-> {playFlagA, playFlagB} == d2[2:1])
    else $error("playback flags wrong");
  AST_RECCLR: assert property (recCntClear |-> $past(frameStart))
    else $error("record clear without frame");
  AST_PLAYCLR: assert property (playCntClear |-> $past(frameStart))
    else $error("playback clear without frame");
  AST_LPWR: assert property (a2 == 7'h3F |-> leftPowerUp == d2[7])
    else $error("left power wrong");
  AST_RPWR: assert property (a2 == 7'h3F |-> rightPowerUp == d2[6])
    else $error("right power wrong");
  AST_LMUTE: assert property (a2 == 7'h40 |-> leftMute == d2[3])
    else $error("left mute wrong");
  AST_RMUTE: assert property (a2 == 7'h40 |-> rightMute == d2[2])
    else $error("right mute wrong");
  AST_GAINRD: assert property (a2 == 7'h41 && $past(regAddr) == 7'h41 |-> regRdData == d2)
    else $error("gain readback wrong");
  AST_UNMAP: assert property ($past(regAddr) > 7'h42 |-> regRdData == 8'h00)
    else $error("unmapped read not zero");
  cover property (a2 == 7'h41);
  cover property (recCntClear);
  cover property (playCntClear);
endmodule
bind dpvc_top dpvc_props props_u (.*);
`default_nettype wire

// [bench/dpvc_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module dpvc_top_test;
  logic sys_clk = 0, rst_b = 0, regWr = 0, frameStart = 0, sampleTick = 0, rangeCompOn = 0;
  logic recFlagA, recFlagB, recCntClear, playFlagA, playFlagB, playCntClear;
  logic leftPowerUp, rightPowerUp, leftMute, rightMute;
  logic [6:0] regAddr = 0, a;
  logic [7:0] regWrData = 0, regRdData, d, leftGainOut, rightGainOut, mdl [62:67];
  logic [23:0] leftSample = 0, rightSample = 0, leftDacIn, rightDacIn;
  logic signed [24:0] avg;
  int bad_count = 0, total_checks = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  dpvc_top dut_u (.*);
  task complete_run;
    $display("mismatches %0d checks %0d", bad_count, total_checks);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run;
    end
  end
  // ****
  // bus and output helpers
  // ****
  task wr(input logic [6:0] wa, input logic [7:0] wd);
    @(posedge sys_clk);
    regWr <= 1;
    regAddr <= wa;
    regWrData <= wd;
    @(posedge sys_clk);
    regWr <= 0;
    if (wa < 67) mdl[wa] = wd;
    #1;
  endtask
  task rdchk;
    for (int i = 62; i < 68; i++) begin
      @(posedge sys_clk);
      regAddr <= 7'(i);
      repeat (2) @(posedge sys_clk);
      #1 `CHK(regRdData, mdl[i])
    end
  endtask
  task outchk;
    `CHK({recFlagA, recFlagB, playFlagA, playFlagB}, {mdl[62][6:5], mdl[62][2:1]})
    `CHK({leftPowerUp, rightPowerUp}, mdl[63][7:6])
    `CHK({leftMute, rightMute}, mdl[64][3:2])
  endtask
  // frame pulses ride along so the clear outputs get exercised
  task tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      sampleTick <= 1;
      frameStart <= 1;
      @(posedge sys_clk);
      sampleTick <= 0;
      frameStart <= 0;
      #1 `CHK(recCntClear, ~mdl[62][4])
      `CHK(playCntClear, ~mdl[62][0])
    end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    void'($urandom(32'h13CD));
    mdl = '{8'h00, 8'h14, 8'h0C, 8'h00, 8'h00, 8'h00};
    repeat (6) @(posedge sys_clk);
    rst_b <= 1;
    #1 outchk;
    rdchk;
    wr(7'h43, 8'hFF);
    repeat (24) begin
      a = 7'h3E + 7'($urandom % 4);
      d = $urandom;
      // stay clear of codes software must not write
      if (a == 7'h40) d[7:4] = 4'h0;
      if (a == 7'h3F && d[1:0] == 2'h3) d[1:0] = 2'h2;
      if (a == 7'h41) d = 8'(int'($urandom % 176) - 127);
      wr(a, d);
      // register stored at the write edge, output one edge later
      @(posedge sys_clk);
      #1 outchk;
    end
    rdchk;
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      leftSample <= $urandom;
      rightSample <= $urandom;
      wr(7'h3F, {2'h3, 2'(c), 2'(c), 2'h2});
      avg = ($signed({leftSample[23], leftSample}) + $signed({rightSample[23], rightSample})) >>> 1;
      @(posedge sys_clk);
      #1;
      `CHK(leftDacIn, c == 0 ? 24'h0 : c == 1 ? leftSample : c == 2 ? rightSample : avg[23:0])
      `CHK(rightDacIn, c == 0 ? 24'h0 : c == 1 ? rightSample : c == 2 ? leftSample : avg[23:0])
    end
    wr(7'h3E, 8'h00);
    wr(7'h40, 8'h00);
    wr(7'h41, 8'h10);
    // applied gain moves one edge after the register, output one edge later
    repeat (2) @(posedge sys_clk);
    #1 `CHK(leftGainOut, 8'h10)
    wr(7'h40, 8'h02);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(rightGainOut, 8'h10)
    @(posedge sys_clk);
    rangeCompOn <= 1;
    wr(7'h40, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 `CHK({leftGainOut, rightGainOut}, 16'h1000)
    @(posedge sys_clk);
    rangeCompOn <= 0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK(leftGainOut, 8'h00)
    wr(7'h3F, 8'hD4);
    wr(7'h40, 8'h00);
    tick(8);
    `CHK(leftGainOut, 8'h08)
    tick(8);
    `CHK(leftGainOut, 8'h10)
    wr(7'h3F, 8'hD5);
    wr(7'h41, 8'h14);
    // half rate: four ticks give only two steps
    tick(4);
    `CHK(leftGainOut, 8'h12)
    tick(4);
    `CHK(leftGainOut, 8'h14)
    complete_run;
  end
endmodule
`default_nettype wire
